// File: src/tlim_pkg.sv
// Constants shared by the temperature limit interrupt logic.
// Assumes a 100 MHz core clock and a byte-wide register link.
package tlim_pkg;
  // Register offsets
  localparam logic [7:0] REG_LOCAL_TEMP    = 8'h00;
  localparam logic [7:0] REG_REMOTE_TEMP   = 8'h01;
  localparam logic [7:0] REG_STATUS        = 8'h02;
  localparam logic [7:0] REG_CONFIG        = 8'h03;
  localparam logic [7:0] REG_LOCAL_HIGH    = 8'h05;
  localparam logic [7:0] REG_LOCAL_LOW     = 8'h06;
  localparam logic [7:0] REG_REMOTE_HIGH   = 8'h07;
  localparam logic [7:0] REG_REMOTE_LOW    = 8'h08;
  localparam logic [7:0] REG_SINGLE_CONV   = 8'h0F;
  localparam logic [7:0] REG_REMOTE_FSLIM  = 8'h19;
  localparam logic [7:0] REG_LOCAL_FSLIM   = 8'h20;
  localparam logic [7:0] REG_HYSTERESIS    = 8'h21;
  // Reset values
  localparam logic [7:0] RST_CONFIG        = 8'h00;
  localparam logic [7:0] RST_HIGH_LIMIT    = 8'h55;
  localparam logic [7:0] RST_LOW_LIMIT     = 8'h00;
  localparam logic [7:0] RST_FS_LIMIT      = 8'h55;
  localparam logic [7:0] RST_HYSTERESIS    = 8'h0A;
  localparam logic [6:0] DEV_ADDR_DEF      = 7'h4C;
  // Config fields
  localparam int CFG_MASK_BIT    = 7;
  localparam int CFG_STANDBY_BIT = 6;
  localparam int CFG_PINMODE_BIT = 5;
  // Status fields
  localparam int ST_BUSY_BIT     = 7;
  localparam int ST_LOC_HIGH_BIT = 6;
  localparam int ST_LOC_LOW_BIT  = 5;
  localparam int ST_REM_HIGH_BIT = 4;
  localparam int ST_REM_LOW_BIT  = 3;
  localparam int ST_OPEN_BIT     = 2;
  localparam int ST_REM_FS_BIT   = 1;
  localparam int ST_LOC_FS_BIT   = 0;
  // Link request kinds
  typedef enum logic [1:0] {
    KIND_READ  = 2'b00,
    KIND_WRITE = 2'b01,
    KIND_ARA   = 2'b10
  } tlim_kind_type;
  // Conversion timing
  localparam int CLK_PERIOD_NS    = 10;
  localparam int CONV_TIME_NS     = 2000;
  localparam int CONV_PERIOD_NS   = 20000;
  localparam int CONV_TIME_CYC    = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_PERIOD_CYC  = CONV_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CNT_W            = 16;
endpackage : tlim_pkg

// File: src/tlim_top.sv
// Temperature limit interrupt logic: limit alert, fail-safe outputs,
// standby and single conversion, open-diode flag, link register access.
// Assumes a converter delivering results on the core clock and a link
// agent that issues one request at a time on its own clock.
`timescale 1ns/10ps
`default_nettype none
module tlim_top
  import tlim_pkg::*;
#(
  parameter int         PERIOD_CYC = CONV_PERIOD_CYC,
  parameter logic [6:0] DEV_ADDR   = DEV_ADDR_DEF
) (
  // Core clock and reset
  input  wire logic       I_CLK,
  input  wire logic       I_RST_N,
  // Link side
  input  wire logic       i_LNK_CLK,
  input  wire logic       i_LNK_REQ,
  input  wire logic [1:0] i_LNK_KIND,
  input  wire logic [7:0] i_LNK_ADDR,
  input  wire logic [7:0] i_LNK_WDATA,
  input  wire logic       i_LNK_ARB_LOST,
  output logic            o_LNK_BUSY,
  output logic            o_LNK_DONE,
  output logic            o_LNK_ACK,
  output logic [7:0]      o_LNK_RDATA,
  // Converter
  input  wire logic [7:0] i_ADC_LOCAL,
  input  wire logic [7:0] i_ADC_REMOTE,
  input  wire logic       i_OPEN_DIODE,
  output logic            o_CONV_RUN,
  // Open-drain pins
  output logic            o_FAILSAFE_OVERTEMP_OUT_N,
  output logic            o_FAILSAFE_OVERTEMP_OE_N,
  output logic            o_LIMIT_ALERT_OUT_N,
  output logic            o_LIMIT_ALERT_OE_N
);

  typedef enum logic {
    CV_IDLE = 1'b0,
    CV_RUN  = 1'b1
  } tlim_conv_type;

  // ---------------- Link domain ----------------
  logic       lk_req_tgl_r, lk_lost_r, lk_busy_r, lk_done_r, lk_ackbit_r;
  logic       lk_ack_s1_r, lk_ack_s2_r, lk_ack_s3_r;
  logic [1:0] lk_kind_r;
  logic [7:0] lk_addr_r, lk_wdata_r, lk_rdata_r;
  wire        lk_take = i_LNK_REQ & ~lk_busy_r;
  wire        lk_ack_evt = lk_ack_s2_r ^ lk_ack_s3_r;

  // New request ignored while one is outstanding
  always_ff @(posedge i_LNK_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      lk_req_tgl_r <= 1'b0;
      lk_kind_r    <= 2'h0;
      lk_addr_r    <= 8'h00;
      lk_wdata_r   <= 8'h00;
      lk_lost_r    <= 1'b0;
    end else if (lk_take) begin
      lk_req_tgl_r <= ~lk_req_tgl_r;
      lk_kind_r    <= i_LNK_KIND;
      lk_addr_r    <= i_LNK_ADDR;
      lk_wdata_r   <= i_LNK_WDATA;
      lk_lost_r    <= i_LNK_ARB_LOST;
    end
  end

  logic       cr_ack_tgl_r;
  logic       cr_ackbit_r;
  logic [7:0] cr_rdata_r;

  always_ff @(posedge i_LNK_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      lk_ack_s1_r <= 1'b0;
      lk_ack_s2_r <= 1'b0;
      lk_ack_s3_r <= 1'b0;
      lk_busy_r   <= 1'b0;
      lk_done_r   <= 1'b0;
      lk_ackbit_r <= 1'b0;
      lk_rdata_r  <= 8'h00;
    end else begin
      lk_ack_s1_r <= cr_ack_tgl_r;
      lk_ack_s2_r <= lk_ack_s1_r;
      lk_ack_s3_r <= lk_ack_s2_r;
      lk_busy_r   <= lk_take | (lk_busy_r & ~lk_ack_evt);
      lk_done_r   <= lk_ack_evt;
      if (lk_ack_evt) begin
        lk_ackbit_r <= cr_ackbit_r;
        lk_rdata_r  <= cr_rdata_r; // Stable: core holds it until next request
      end
    end
  end

  assign o_LNK_BUSY  = lk_busy_r;
  assign o_LNK_DONE  = lk_done_r;
  assign o_LNK_ACK   = lk_ackbit_r;
  assign o_LNK_RDATA = lk_rdata_r;

  // ---------------- Core domain ----------------
  logic cr_req_s1_r, cr_req_s2_r, cr_req_s3_r, cr_open_s1_r, cr_open_s2_r;

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cr_req_s1_r  <= 1'b0;
      cr_req_s2_r  <= 1'b0;
      cr_req_s3_r  <= 1'b0;
      cr_open_s1_r <= 1'b0;
      cr_open_s2_r <= 1'b0;
    end else begin
      cr_req_s1_r  <= lk_req_tgl_r;
      cr_req_s2_r  <= cr_req_s1_r;
      cr_req_s3_r  <= cr_req_s2_r;
      cr_open_s1_r <= i_OPEN_DIODE;
      cr_open_s2_r <= cr_open_s1_r;
    end
  end

  // Request fields are stable while the toggle crosses
  wire req_evt = cr_req_s2_r ^ cr_req_s3_r;
  wire req_wr  = req_evt & (lk_kind_r == KIND_WRITE);
  wire req_rd  = req_evt & (lk_kind_r == KIND_READ);
  wire req_ara = req_evt & (lk_kind_r == KIND_ARA);

  logic [7:0]       cfg_r, loc_high_r, loc_low_r, rem_high_r, rem_low_r;
  logic [7:0]       loc_fs_r, rem_fs_r, hyst_r, loc_temp_r, rem_temp_r;
  logic [6:0]       flag_r;
  logic             open_det_r, alert_lat_r, ara_seen_r, oneshot_r, conv_run_r;
  logic             fs_loc_r, fs_rem_r, fs2_loc_r, fs2_rem_r, pin_oe_n_r, fs_oe_n_r;
  tlim_conv_type    cv_state_r, cv_state_nxt;
  logic [CNT_W-1:0] per_cnt_r, cv_cnt_r;

  wire standby  = cfg_r[CFG_STANDBY_BIT];
  wire pin_fs2  = cfg_r[CFG_PINMODE_BIT];
  wire oneshot  = req_wr & (lk_addr_r == REG_SINGLE_CONV);
  wire per_hit  = (per_cnt_r == '0) & ~standby;
  wire cv_start = (cv_state_r == CV_IDLE) & (oneshot | per_hit);
  wire cv_end   = (cv_state_r == CV_RUN) & (cv_cnt_r == '0);
  wire cv_abort = (cv_state_r == CV_RUN) & standby & ~oneshot_r;

  // Live conditions from stored results and current limits
  wire [6:0] cond;
  assign cond[ST_LOC_HIGH_BIT] = loc_temp_r > loc_high_r;
  assign cond[ST_LOC_LOW_BIT]  = loc_temp_r <= loc_low_r;
  assign cond[ST_REM_HIGH_BIT] = rem_temp_r > rem_high_r;
  assign cond[ST_REM_LOW_BIT]  = rem_temp_r <= rem_low_r;
  assign cond[ST_OPEN_BIT]     = open_det_r;
  assign cond[ST_REM_FS_BIT]   = fs_rem_r;
  assign cond[ST_LOC_FS_BIT]   = fs_loc_r;

  wire status_rd = req_rd & (lk_addr_r == REG_STATUS);
  wire alert_cause = |flag_r[ST_LOC_HIGH_BIT:ST_OPEN_BIT];
  wire alert_set = alert_cause & ~cfg_r[CFG_MASK_BIT] & ~pin_fs2;
  wire alert_clr = alert_lat_r & ara_seen_r & ~alert_cause
                 & ~|cond[ST_LOC_HIGH_BIT:ST_OPEN_BIT];
  wire ara_ans   = req_ara & alert_lat_r & ~pin_fs2;
  wire ara_won   = ara_ans & ~lk_lost_r;

  // Sticky flags; a set in the clearing cycle wins
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_flag
      always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) flag_r[gi] <= 1'b0;
        else flag_r[gi] <= cond[gi] | (flag_r[gi] & ~status_rd);
      end
    end
  endgenerate

  wire [7:0] status_val = {conv_run_r, flag_r};
  wire [7:0] rd_mux =
      (lk_addr_r == REG_LOCAL_TEMP)   ? loc_temp_r :
      (lk_addr_r == REG_REMOTE_TEMP)  ? rem_temp_r :
      (lk_addr_r == REG_STATUS)       ? status_val :
      (lk_addr_r == REG_CONFIG)       ? cfg_r      :
      (lk_addr_r == REG_LOCAL_HIGH)   ? loc_high_r :
      (lk_addr_r == REG_LOCAL_LOW)    ? loc_low_r  :
      (lk_addr_r == REG_REMOTE_HIGH)  ? rem_high_r :
      (lk_addr_r == REG_REMOTE_LOW)   ? rem_low_r  :
      (lk_addr_r == REG_REMOTE_FSLIM) ? rem_fs_r   :
      (lk_addr_r == REG_LOCAL_FSLIM)  ? loc_fs_r   :
      (lk_addr_r == REG_HYSTERESIS)   ? hyst_r     : 8'h00;
  wire [7:0] ans_data = req_ara ? {DEV_ADDR, 1'b1} : rd_mux;
  wire       ans_ack  = req_ara ? ara_won : 1'b1;

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cr_ack_tgl_r <= 1'b0;
      cr_ackbit_r  <= 1'b0;
      cr_rdata_r   <= 8'h00;
    end else if (req_evt) begin
      cr_ack_tgl_r <= ~cr_ack_tgl_r;
      cr_ackbit_r  <= ans_ack;
      cr_rdata_r   <= ans_data;
    end
  end

  // Writable registers; no write to the single-conversion offset is stored
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cfg_r      <= RST_CONFIG;
      loc_high_r <= RST_HIGH_LIMIT;
      loc_low_r  <= RST_LOW_LIMIT;
      rem_high_r <= RST_HIGH_LIMIT;
      rem_low_r  <= RST_LOW_LIMIT;
      loc_fs_r   <= RST_FS_LIMIT;
      rem_fs_r   <= RST_FS_LIMIT;
      hyst_r     <= RST_HYSTERESIS;
    end else if (req_wr) begin
      if (lk_addr_r == REG_CONFIG)       cfg_r      <= lk_wdata_r;
      if (lk_addr_r == REG_LOCAL_HIGH)   loc_high_r <= lk_wdata_r;
      if (lk_addr_r == REG_LOCAL_LOW)    loc_low_r  <= lk_wdata_r;
      if (lk_addr_r == REG_REMOTE_HIGH)  rem_high_r <= lk_wdata_r;
      if (lk_addr_r == REG_REMOTE_LOW)   rem_low_r  <= lk_wdata_r;
      if (lk_addr_r == REG_LOCAL_FSLIM)  loc_fs_r   <= lk_wdata_r;
      if (lk_addr_r == REG_REMOTE_FSLIM) rem_fs_r   <= lk_wdata_r;
      if (lk_addr_r == REG_HYSTERESIS)   hyst_r     <= lk_wdata_r;
    end
  end

  // Conversion sequencer
  always_comb begin
    cv_state_nxt = cv_state_r;
    case (cv_state_r)
      CV_IDLE: if (cv_start) cv_state_nxt = CV_RUN;
      CV_RUN:  if (cv_abort | cv_end) cv_state_nxt = CV_IDLE;
      default: cv_state_nxt = CV_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cv_state_r <= CV_IDLE;
      conv_run_r <= 1'b0;
      per_cnt_r  <= '0;
      cv_cnt_r   <= '0;
      oneshot_r  <= 1'b0;
      open_det_r <= 1'b0;
      loc_temp_r <= 8'h00;
      rem_temp_r <= 8'h00;
    end else begin
      cv_state_r <= cv_state_nxt;
      conv_run_r <= (cv_state_nxt == CV_RUN);
      per_cnt_r  <= (per_hit | standby) ? CNT_W'(PERIOD_CYC - 1) : per_cnt_r - 1'b1;
      if (cv_start) begin
        cv_cnt_r   <= CNT_W'(CONV_TIME_CYC - 1);
        oneshot_r  <= oneshot;
        open_det_r <= cr_open_s2_r;
      end else if (cv_state_r == CV_RUN) begin
        cv_cnt_r <= cv_cnt_r - 1'b1;
      end
      if (cv_end & ~cv_abort) begin
        loc_temp_r <= i_ADC_LOCAL;
        rem_temp_r <= i_ADC_REMOTE;
      end
    end
  end

  // Hysteresis comparator: set above limit, release at limit minus hysteresis
  function automatic logic fs_next(input logic act, input logic [7:0] t,
                                   input logic [7:0] lim, input logic [7:0] hy);
    logic [7:0] rel;
    rel = (lim > hy) ? 8'(lim - hy) : 8'h00;
    if (t > lim) fs_next = 1'b1;
    else if (t <= rel) fs_next = 1'b0;
    else fs_next = act;
  endfunction : fs_next

  // Fail-safe paths carry no mask by design
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      fs_loc_r    <= 1'b0;
      fs_rem_r    <= 1'b0;
      fs2_loc_r   <= 1'b0;
      fs2_rem_r   <= 1'b0;
      alert_lat_r <= 1'b0;
      ara_seen_r  <= 1'b0;
      pin_oe_n_r  <= 1'b1;
      fs_oe_n_r   <= 1'b1;
    end else begin
      fs_loc_r    <= fs_next(fs_loc_r, loc_temp_r, loc_fs_r, hyst_r);
      fs_rem_r    <= fs_next(fs_rem_r, rem_temp_r, rem_fs_r, hyst_r);
      fs2_loc_r   <= fs_next(fs2_loc_r, loc_temp_r, loc_high_r, hyst_r);
      fs2_rem_r   <= fs_next(fs2_rem_r, rem_temp_r, rem_high_r, hyst_r);
      alert_lat_r <= alert_set | (alert_lat_r & ~alert_clr);
      ara_seen_r  <= (ara_seen_r | ara_won) & ~alert_clr & alert_lat_r;
      pin_oe_n_r  <= pin_fs2 ? ~(fs2_loc_r | fs2_rem_r) : ~alert_lat_r;
      fs_oe_n_r   <= ~(fs_loc_r | fs_rem_r);
    end
  end

  // Pins only ever drive low; release is by enable
  assign o_LIMIT_ALERT_OUT_N       = 1'b0;
  assign o_LIMIT_ALERT_OE_N        = pin_oe_n_r;
  assign o_FAILSAFE_OVERTEMP_OUT_N = 1'b0;
  assign o_FAILSAFE_OVERTEMP_OE_N  = fs_oe_n_r;
  assign o_CONV_RUN                = conv_run_r;

  // ---------------- Assertions ----------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  a_flag_set_wins: assert property (cond[ST_OPEN_BIT] |=> flag_r[ST_OPEN_BIT])
    else $error("open flag lost while condition present");
  a_status_clear: assert property (status_rd && !cond[ST_LOC_HIGH_BIT]
      |=> !flag_r[ST_LOC_HIGH_BIT])
    else $error("status read did not clear idle flag");
  a_alert_pin_low: assert property (alert_lat_r && !pin_fs2 |=> !o_LIMIT_ALERT_OE_N)
    else $error("alert latched but pin released");
  a_alert_release: assert property ($fell(alert_lat_r) |-> $past(ara_seen_r))
    else $error("alert released without alert response");
  a_alert_cause: assert property (alert_lat_r
      && (|cond[ST_LOC_HIGH_BIT:ST_OPEN_BIT]) |=> alert_lat_r)
    else $error("alert released while cause present");
  a_ara_answer: assert property (ara_won |=> cr_rdata_r == {DEV_ADDR, 1'b1} && cr_ackbit_r)
    else $error("alert response answer wrong");
  a_fs_set: assert property (rem_temp_r > rem_fs_r |=> ##1 !o_FAILSAFE_OVERTEMP_OE_N)
    else $error("fail-safe not asserted above limit");
  a_fs_hold: assert property (fs_loc_r && loc_temp_r > loc_fs_r - hyst_r
      && loc_fs_r >= hyst_r |=> fs_loc_r)
    else $error("fail-safe released inside hysteresis band");
  a_standby_abort: assert property (cv_abort |=> cv_state_r == CV_IDLE
      && $stable(loc_temp_r) && $stable(rem_temp_r))
    else $error("standby abort updated results");
  a_oneshot_go: assert property (oneshot && cv_state_r == CV_IDLE |=> o_CONV_RUN)
    else $error("single conversion did not start");
  a_open_sample: assert property (cv_start |=> open_det_r == $past(cr_open_s2_r))
    else $error("open comparator not sampled at start");
  a_pin_fs2: assert property (pin_fs2 && fs2_loc_r |=> !o_LIMIT_ALERT_OE_N)
    else $error("second fail-safe not driven");

  c_alert_serviced: cover property (alert_lat_r ##[1:400] $fell(alert_lat_r));
  c_standby_oneshot: cover property (standby && oneshot ##[1:300] cv_end);
  c_fs_cycle: cover property ($rose(fs_loc_r) ##[1:500] $fell(fs_loc_r));
  c_abort: cover property (cv_abort);

endmodule : tlim_top
`default_nettype wire

// File: tb/temp_limit_interrupt_logic_test.sv
// Self-checking bench for the temperature limit interrupt logic.
// Assumes the link host model in tlim_link_host and pulled-up pins.
`timescale 1ns/10ps
`default_nettype none
module temp_limit_interrupt_logic_test
  import tlim_pkg::*;
;
  logic       clk, lnk_clk, rst_n, req, lost, busy, done, ack, open_d, conv_run;
  logic       fs_out_n, fs_oe_n, al_out_n, al_oe_n;
  logic [1:0] kind;
  logic [7:0] addr, wdata, rdata, adc_loc, adc_rem;
  wire        alert_line = al_oe_n ? 1'b1 : al_out_n;
  wire        fs_line    = fs_oe_n ? 1'b1 : fs_out_n;
  int         fails, total_checks;
  logic [7:0] tbl_a [8] = '{REG_CONFIG, REG_LOCAL_HIGH, REG_REMOTE_HIGH, REG_LOCAL_LOW,
                            REG_REMOTE_LOW, REG_LOCAL_FSLIM, REG_REMOTE_FSLIM, REG_HYSTERESIS};
  logic [7:0] tbl_v [8] = '{8'h00, 8'h55, 8'h55, 8'h00, 8'h00, 8'h55, 8'h55, 8'h0A};

  // Short period keeps the run brief; conversions stay 200 cycles
  tlim_top #(.PERIOD_CYC(300)) dut (
    .I_CLK(clk), .I_RST_N(rst_n), .i_LNK_CLK(lnk_clk), .i_LNK_REQ(req), .i_LNK_KIND(kind),
    .i_LNK_ADDR(addr), .i_LNK_WDATA(wdata), .i_LNK_ARB_LOST(lost), .o_LNK_BUSY(busy),
    .o_LNK_DONE(done), .o_LNK_ACK(ack), .o_LNK_RDATA(rdata), .i_ADC_LOCAL(adc_loc),
    .i_ADC_REMOTE(adc_rem), .i_OPEN_DIODE(open_d), .o_CONV_RUN(conv_run),
    .o_FAILSAFE_OVERTEMP_OUT_N(fs_out_n), .o_FAILSAFE_OVERTEMP_OE_N(fs_oe_n),
    .o_LIMIT_ALERT_OUT_N(al_out_n), .o_LIMIT_ALERT_OE_N(al_oe_n));

  tlim_link_host host (
    .i_clk(lnk_clk), .i_busy(busy), .i_done(done), .i_ack(ack), .i_rdata(rdata),
    .i_alert_line(alert_line), .o_req(req), .o_kind(kind), .o_addr(addr),
    .o_wdata(wdata), .o_arb_lost(lost));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    lnk_clk = 1'b0;
    #3;
    forever #24 lnk_clk = ~lnk_clk;
  end

  task automatic finish_test();
    fails += host.timeouts;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check8

  task automatic check1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check1

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
    logic       k;
    logic [7:0] d;
    host.xfer(KIND_READ, a, 8'h00, 1'b0, k, d);
    check8(d & m, exp);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic       k;
    logic [7:0] d;
    host.xfer(KIND_WRITE, a, v, 1'b0, k, d);
  endtask : wr

  task automatic ara(input logic lst, input logic exp_ack);
    logic       k;
    logic [7:0] d;
    host.xfer(KIND_ARA, 8'h00, 8'h00, lst, k, d);
    check1(k, exp_ack);
    check8(d, {DEV_ADDR_DEF, 1'b1});
    repeat (8) @(posedge clk);
  endtask : ara

  task automatic conv();
    int n;
    n = 0;
    // Results land at the end edge; skip one edge so a just-ended run is not taken
    @(posedge clk);
    while (conv_run !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    while (conv_run !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    check1(n < 1000, 1'b1);
    repeat (6) @(posedge clk);
  endtask : conv

  task automatic quiet();
    logic seen;
    seen = 1'b0;
    repeat (700) begin
      @(posedge clk);
      if (conv_run !== 1'b0) seen = 1'b1;
    end
    check1(seen, 1'b0);
  endtask : quiet

  task automatic clear();
    logic       k;
    logic [7:0] d;
    host.xfer(KIND_READ, REG_STATUS, 8'h00, 1'b0, k, d);
    host.service_alert();
    repeat (8) @(posedge clk);
  endtask : clear

  task automatic set_adc(input logic [7:0] l, input logic [7:0] r, input logic o);
    @(posedge clk);
    adc_loc <= l;
    adc_rem <= r;
    open_d <= o;
  endtask : set_adc

  initial begin
    fails = 0;
    total_checks = 0;
    rst_n = 1'b0;
    adc_loc = 8'h30;
    adc_rem = 8'h30;
    open_d = 1'b0;
    // Reset spans both clocks
    repeat (3) @(posedge lnk_clk);
    rst_n <= 1'b1;
    // Fail-safe limits left at or above high limits
    for (int i = 0; i < 8; i++) rd(tbl_a[i], tbl_v[i]);
    wr(REG_HYSTERESIS, 8'h03);
    rd(REG_HYSTERESIS, 8'h03);
    wr(REG_HYSTERESIS, 8'h0A);
    conv();
    conv();
    check1(alert_line, 1'b0);
    ara(1'b0, 1'b1);
    check1(alert_line, 1'b0);
    rd(REG_STATUS, 8'h28, 8'h7F);
    repeat (8) @(posedge clk);
    check1(alert_line, 1'b1);
    rd(REG_STATUS, 8'h00, 8'h7F);
    set_adc(8'h60, 8'h30, 1'b0);
    conv();
    check1(alert_line, 1'b0);
    check1(fs_line, 1'b0);
    ara(1'b0, 1'b1);
    check1(alert_line, 1'b0);
    rd(REG_STATUS, 8'h41, 8'h7F);
    set_adc(8'h4C, 8'h30, 1'b0);
    conv();
    check1(fs_line, 1'b0);
    set_adc(8'h4B, 8'h30, 1'b0);
    conv();
    check1(fs_line, 1'b1);
    clear();
    check1(alert_line, 1'b1);
    wr(REG_CONFIG, 8'h80);
    set_adc(8'h30, 8'h60, 1'b0);
    conv();
    check1(fs_line, 1'b0);
    check1(alert_line, 1'b1);
    set_adc(8'h30, 8'h30, 1'b0);
    conv();
    check1(fs_line, 1'b1);
    clear();
    wr(REG_CONFIG, 8'hA0);
    set_adc(8'h60, 8'h30, 1'b0);
    conv();
    check1(alert_line, 1'b0);
    ara(1'b0, 1'b0);
    set_adc(8'h4C, 8'h30, 1'b0);
    conv();
    check1(alert_line, 1'b0);
    set_adc(8'h4B, 8'h30, 1'b0);
    conv();
    check1(alert_line, 1'b1);
    clear();
    wr(REG_CONFIG, 8'h00);
    repeat (8) @(posedge clk);
    check1(alert_line, 1'b1);
    // Open input is sampled at start only: wait for a run begun after the change
    set_adc(8'h4B, 8'h30, 1'b1);
    conv();
    conv();
    check1(alert_line, 1'b0);
    rd(REG_STATUS, 8'h04, 8'h04);
    ara(1'b1, 1'b0);
    check1(alert_line, 1'b0);
    set_adc(8'h50, 8'h30, 1'b0);
    conv();
    conv();
    clear();
    check1(alert_line, 1'b1);
    set_adc(8'h4B, 8'h30, 1'b0);
    conv();
    set_adc(8'h50, 8'h30, 1'b0);
    while (conv_run !== 1'b1) @(posedge clk);
    wr(REG_CONFIG, 8'h40);
    quiet();
    rd(REG_LOCAL_TEMP, 8'h4B);
    rd(REG_CONFIG, 8'h40);
    wr(REG_SINGLE_CONV, 8'hA5);
    rd(REG_STATUS, 8'h80, 8'h80);
    conv();
    rd(REG_LOCAL_TEMP, 8'h50);
    rd(REG_SINGLE_CONV, 8'h00);
    quiet();
    wr(REG_LOCAL_LOW, 8'h50);
    repeat (8) @(posedge clk);
    check1(alert_line, 1'b0);
    finish_test();
  end

  initial begin
    // Tests need about 70 us; over five times that with margin
    #400us;
    fails++;
    finish_test();
  end
endmodule : temp_limit_interrupt_logic_test
`default_nettype wire

// File: tb/tlim_link_host.sv
// Link host model: one register request at a time, alert servicing.
// Assumes the block answers each request with a single done pulse.
`timescale 1ns/10ps
`default_nettype none
module tlim_link_host
  import tlim_pkg::*;
(
  // Link clock and answer
  input  wire logic       i_clk,
  input  wire logic       i_busy,
  input  wire logic       i_done,
  input  wire logic       i_ack,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_alert_line,
  // Request
  output var logic        o_req,
  output var logic [1:0]  o_kind,
  output var logic [7:0]  o_addr,
  output var logic [7:0]  o_wdata,
  output var logic        o_arb_lost
);
  int timeouts;
  initial begin
    timeouts = 0;
    o_req = 1'b0;
    o_kind = KIND_READ;
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_arb_lost = 1'b0;
  end

  task automatic xfer(input logic [1:0] kind, input logic [7:0] addr, input logic [7:0] wdata,
                      input logic lost, output logic ack, output logic [7:0] rdata);
    int n;
    n = 0;
    @(posedge i_clk);
    o_req <= 1'b1;
    o_kind <= kind;
    o_addr <= addr;
    o_wdata <= wdata;
    o_arb_lost <= lost;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_busy !== 1'b1 && n < 20);
    o_req <= 1'b0;
    // Released lines carry no stale value
    o_addr <= ~addr;
    o_wdata <= ~wdata;
    o_arb_lost <= ~lost;
    while (i_done !== 1'b1 && n < 40) begin
      @(posedge i_clk);
      n++;
    end
    // A hung link counts against the run
    if (n >= 20) begin
      timeouts++;
      $display("mismatch at %0t got %h exp %h", $time, n, 20);
    end
    ack = i_ack;
    rdata = i_rdata;
  endtask : xfer

  task automatic service_alert();
    int k;
    logic a;
    logic [7:0] d;
    k = 0;
    while (i_alert_line === 1'b0 && k < 4) begin
      xfer(KIND_ARA, 8'h00, 8'h00, 1'b0, a, d);
      k++;
      repeat (4) @(posedge i_clk);
    end
  endtask : service_alert
endmodule : tlim_link_host
`default_nettype wire
